// file: pphp_pkg.sv
package pphp_pkg;
    // register byte offsets on the apb slave
    localparam logic [7:0] PPHP_REG_CMD = 8'h00;
    localparam logic [7:0] PPHP_REG_DOUT = 8'h04;
    localparam logic [7:0] PPHP_REG_DIN = 8'h08;
    localparam logic [7:0] PPHP_REG_STATUS = 8'h0c;
    localparam logic [7:0] PPHP_REG_AUX = 8'h10;
    localparam logic [7:0] PPHP_REG_DIRECT = 8'h14;
    localparam logic [7:0] PPHP_REG_DELAY = 8'h18;
    // command register field positions
    localparam int PPHP_CMD_GO = 0;
    localparam int PPHP_CMD_INPUT = 1;
    localparam int PPHP_CMD_WORD = 2;
    localparam int PPHP_CMD_PAIR = 3;
    localparam int PPHP_CMD_IFRST = 4;
    // reset values
    localparam logic [7:0] PPHP_DELAY_RST = 8'h04;
    localparam logic [1:0] PPHP_AUX_RST = 2'h0;
    // peripheral reset pulse: least time, rounded up to whole cycles
    localparam int PPHP_CLK_MHZ = 100;
    localparam int PPHP_RESET_US = 15;
    localparam logic [10:0] PPHP_RESET_CYC =
        11'(PPHP_RESET_US * PPHP_CLK_MHZ);
    typedef enum logic [2:0] {
        PPHP_S_IDLE = 3'b000,
        PPHP_S_ARM = 3'b001,
        PPHP_S_DELAY = 3'b010,
        PPHP_S_STROBE = 3'b011,
        PPHP_S_RDYWAIT = 3'b100
    } pphp_fsm_t;
endpackage

// file: pphp_sync2.sv
`timescale 1ns/1ps
module pphp_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw level and its synchronised view
    input wire logic d,
    output logic q,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } pphp_sync_t;
    pphp_sync_t st_q, st_d;

    // s1 only feeds s2; edges are taken between s2 and s3
    always_comb begin
        st_d = '{s1: d, s2: st_q.s1, s3: st_q.s2};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // one pulse per transition of the flag
    assign q = st_q.s2; // R23
    assign rise = st_q.s2 & ~st_q.s3; // R23
    assign fall = ~st_q.s2 & st_q.s3; // R23
endmodule

// file: pphp_timer.sv
`timescale 1ns/1ps
module pphp_timer #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // load a count, busy until it has run down
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic busy
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } pphp_tmr_t;
    pphp_tmr_t st_q, st_d;

    // a reload restarts the count, which suits repeated interface resets
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.cnt = value;
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = (st_q.cnt != '0);
endmodule

// file: pphp_port.sv
`timescale 1ns/1ps
// Functional notes
// [R1] pulse mode starts the next transfer once the strobe clears, no ready
// [R2] output: direction low, data out, strobe delay, then strobe set
// [R3] ready-to-busy flag edge clears the strobe by itself
// [R4] peripheral takes output data before strobe clears (busy pulses)
// [R5] input: direction high, then strobe set, no ready check; code sets both on one edge and checks ready in full mode
// [R6] busy-edge clocking: peripheral settles data before going busy
// [R7] pulse ready-edge clocking: sample after strobe clears
// [R8] ready pulses: busy clears strobe; data valid while strobe set
// [R9] ready-pulse peripherals: pulse mode or full mode, inverted flag
// [R10] ready pulses, busy-edge: data settled before flag returns busy
// [R11] ready pulses, ready-edge: data settled before flag goes ready
// [R12] interface reset pulses peripheral reset low at least 15 us
// [R13] interface reset clears the strobe
// [R14] interface reset zeroes data out only when clear option fitted
// [R15] interface reset leaves aux outputs and direction alone
// [R16] bytes by default, most significant byte first
// [R17] word commands and direct register move full 16-bit words
// [R18] byte output on low eight lines, upper eight driven zero
// [R19] data line levels follow configured polarity
// [R20] full mode starts only with strobe clear and flag ready
// [R21] direction high for input, low for output, fixed polarity
// [R22] a static input selects full or pulse handshake
// [R23] flag synchronised, each edge acted on exactly once
module pphp_port
    import pphp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // static configuration
    input wire logic handshake_mode_select,
    input wire logic busy_edge_clocking,
    input wire logic strobe_active_low,
    input wire logic flag_active_low,
    input wire logic data_active_low,
    input wire logic dout_clear_fitted,
    // peripheral link
    input wire logic peripheral_flag,
    input wire logic [15:0] data_in,
    output logic peripheral_control_strobe,
    output logic direction_in,
    output logic [15:0] data_out,
    output logic aux_output_zero,
    output logic aux_output_one,
    output logic periph_reset_n
);
    import pphp_pkg::*;

    typedef struct packed {
        pphp_fsm_t fsm;
        logic inp;
        logic word;
        logic pair;
        logic second;
        logic [15:0] tx;
        logic [15:0] rx;
        logic rx_valid;
        logic strobe;
        logic strobe_pin;
        logic dir_pin;
        logic [15:0] dout_pin;
        logic [1:0] aux;
        logic [1:0] aux_pin;
        logic [7:0] dly;
        logic ifc_rst;
        logic preset_n;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pphp_state_t;
    pphp_state_t st_q, st_d;

    logic flag_s;
    logic flag_rise;
    logic flag_fall;
    logic busy_lvl;
    logic to_busy;
    logic to_ready;
    logic dly_load;
    logic dly_busy;
    logic rst_busy;
    logic [15:0] pol;
    logic [15:0] din_l;
    logic [15:0] tx_l;
    logic acc;
    logic wr;
    logic rd;
    logic pulse;

    pphp_sync2 u_flag (
        .clk(clk),
        .rst(rst),
        .d(peripheral_flag),
        .q(flag_s),
        .rise(flag_rise),
        .fall(flag_fall)
    );

    pphp_timer #(.W(8)) u_dly (
        .clk(clk),
        .rst(rst),
        .load(dly_load),
        .value(st_q.dly),
        .busy(dly_busy)
    );

    pphp_timer #(.W(11)) u_prst (
        .clk(clk),
        .rst(rst),
        .load(st_q.ifc_rst),
        .value(PPHP_RESET_CYC),
        .busy(rst_busy)
    );

    // flag polarity folded in so busy means busy whatever the pin sense
    assign busy_lvl = flag_s ^ flag_active_low;
    assign to_busy = flag_active_low ? flag_fall : flag_rise; // R23
    assign to_ready = flag_active_low ? flag_rise : flag_fall; // R23
    assign pulse = handshake_mode_select; // R22
    assign pol = {16{data_active_low}};
    assign din_l = data_in ^ pol; // R19
    // byte sequence: high byte first when a pair is sent
    always_comb begin
        if (st_q.word) begin
            tx_l = st_q.tx; // R17
        end else if (st_q.pair && !st_q.second) begin
            tx_l = {8'h00, st_q.tx[15:8]}; // R16 R18
        end else begin
            tx_l = {8'h00, st_q.tx[7:0]}; // R18
        end
    end
    // a request completes at the edge where pready is seen high
    assign acc = psel & penable & st_q.pready;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign dly_load = (st_q.fsm == PPHP_S_ARM) && !st_q.inp && !st_q.ifc_rst
        && (pulse || (!busy_lvl && !st_q.strobe));

    // one next-state process for bus, handshake and reset actions
    always_comb begin
        logic [15:0] cap;
        logic done;
        cap = st_q.rx;
        done = 1'b0;
        st_d = st_q;
        st_d.ifc_rst = 1'b0;
        // apb: one wait cycle, then the answer
        st_d.pready = psel & penable & ~st_q.pready;
        if (psel && penable && !st_q.pready) begin
            st_d.pslverr = 1'b0;
            st_d.prdata = 32'h0000_0000;
            unique case (paddr)
                PPHP_REG_CMD: st_d.prdata = 32'h0000_0000;
                PPHP_REG_DOUT: st_d.prdata = {16'h0000, st_q.tx};
                PPHP_REG_DIN: st_d.prdata = {16'h0000, st_q.rx};
                PPHP_REG_STATUS: st_d.prdata = {27'h0, st_q.rx_valid,
                    ~st_q.preset_n, busy_lvl, st_q.strobe,
                    st_q.fsm != PPHP_S_IDLE};
                PPHP_REG_AUX: st_d.prdata = {30'h0, st_q.aux};
                PPHP_REG_DIRECT: st_d.prdata = {16'h0000, din_l}; // R17
                PPHP_REG_DELAY: st_d.prdata = {24'h0, st_q.dly};
                default: st_d.pslverr = 1'b1;
            endcase
        end
        // register writes and read side effects
        if (wr) begin
            unique case (paddr)
                PPHP_REG_CMD: begin
                    if (pwdata[PPHP_CMD_IFRST]) begin
                        st_d.ifc_rst = 1'b1;
                    end else if (pwdata[PPHP_CMD_GO]
                                 && st_q.fsm == PPHP_S_IDLE) begin
                        st_d.inp = pwdata[PPHP_CMD_INPUT];
                        st_d.word = pwdata[PPHP_CMD_WORD];
                        st_d.pair = pwdata[PPHP_CMD_PAIR];
                        st_d.second = 1'b0;
                        st_d.fsm = PPHP_S_ARM;
                    end
                end
                PPHP_REG_DOUT: st_d.tx = pwdata[15:0];
                PPHP_REG_AUX: st_d.aux = pwdata[1:0];
                PPHP_REG_DELAY: st_d.dly = pwdata[7:0];
                PPHP_REG_DIRECT: begin
                    // no handshake: only data lines and direction move
                    if (st_q.fsm == PPHP_S_IDLE) begin
                        st_d.dout_pin = pwdata[15:0] ^ pol; // R17 R19
                        st_d.dir_pin = 1'b0; // R21
                    end
                end
                default: st_d.tx = st_q.tx;
            endcase
        end
        if (rd && paddr == PPHP_REG_DIN) begin
            st_d.rx_valid = 1'b0;
        end
        if (rd && paddr == PPHP_REG_DIRECT && st_q.fsm == PPHP_S_IDLE) begin
            st_d.dir_pin = 1'b1; // R21
        end
        // handshake sequencer
        unique case (st_q.fsm)
            PPHP_S_IDLE: st_d.fsm = st_d.fsm;
            PPHP_S_ARM: begin
                // pulse mode skips the ready check
                if (pulse || (!busy_lvl && !st_q.strobe)) begin // R1 R20
                    st_d.dir_pin = st_q.inp; // R21
                    if (st_q.inp) begin
                        st_d.strobe = 1'b1; // R5
                        st_d.fsm = PPHP_S_STROBE;
                    end else begin
                        st_d.dout_pin = tx_l ^ pol; // R2 R19
                        st_d.fsm = PPHP_S_DELAY;
                    end
                end
            end
            PPHP_S_DELAY: begin
                if (!dly_busy) begin
                    st_d.strobe = 1'b1; // R2
                    st_d.fsm = PPHP_S_STROBE;
                end
            end
            PPHP_S_STROBE: begin
                if (to_busy) begin
                    st_d.strobe = 1'b0; // R3 R8
                    if (!st_q.inp) begin
                        done = 1'b1; // R4
                    end else if (busy_edge_clocking || pulse) begin
                        cap = din_l; // R6 R7 R10
                        done = 1'b1;
                    end else begin
                        st_d.fsm = PPHP_S_RDYWAIT;
                    end
                end
            end
            PPHP_S_RDYWAIT: begin
                if (to_ready) begin
                    cap = din_l; // R11
                    done = 1'b1;
                end
            end
            default: st_d.fsm = PPHP_S_IDLE;
        endcase
        // store captured input; the msb byte of a pair comes first
        if (done) begin
            if (st_q.inp) begin
                if (st_q.word) begin
                    st_d.rx = cap; // R17
                end else if (st_q.pair && !st_q.second) begin
                    st_d.rx = {cap[7:0], 8'h00}; // R16
                end else if (st_q.pair) begin
                    st_d.rx = {st_q.rx[15:8], cap[7:0]};
                end else begin
                    st_d.rx = {8'h00, cap[7:0]};
                end
            end
            if (st_q.pair && !st_q.word && !st_q.second) begin
                st_d.second = 1'b1;
                st_d.fsm = PPHP_S_ARM; // R1
            end else begin
                st_d.fsm = PPHP_S_IDLE;
                st_d.rx_valid = st_q.rx_valid | st_q.inp;
            end
        end
        // interface reset wins over the sequencer, not over aux or dir
        if (st_q.ifc_rst) begin
            st_d.fsm = PPHP_S_IDLE;
            st_d.strobe = 1'b0; // R13
            st_d.second = 1'b0;
            if (dout_clear_fitted) begin
                st_d.dout_pin = 16'h0000; // R14
            end else begin
                st_d.dout_pin = st_q.dout_pin; // R14
            end
            st_d.aux = st_q.aux; // R15
            st_d.dir_pin = st_q.dir_pin; // R15
        end
        st_d.strobe_pin = st_d.strobe ^ strobe_active_low;
        // a set aux bit drives its line low
        st_d.aux_pin = ~st_d.aux; // R15
        st_d.preset_n = ~(st_q.ifc_rst | rst_busy); // R12
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.fsm <= PPHP_S_IDLE;
            st_q.dly <= PPHP_DELAY_RST;
            st_q.aux <= PPHP_AUX_RST;
            st_q.aux_pin <= ~PPHP_AUX_RST;
            // a low-true strobe must not look set while reset is held
            st_q.strobe_pin <= strobe_active_low;
            st_q.preset_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign peripheral_control_strobe = st_q.strobe_pin;
    assign direction_in = st_q.dir_pin;
    assign data_out = st_q.dout_pin;
    // aux lines are kept at pin level so no gate follows the flop
    assign aux_output_zero = st_q.aux_pin[0];
    assign aux_output_one = st_q.aux_pin[1];
    assign periph_reset_n = st_q.preset_n;

    // helper: length of the current low phase of the peripheral reset
    logic [11:0] low_cnt_q;
    always_ff @(posedge clk) begin
        if (rst || st_q.preset_n) begin
            low_cnt_q <= 12'h000;
        end else if (low_cnt_q != 12'hfff) begin
            low_cnt_q <= low_cnt_q + 12'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_ifc_rst;
        st_q.ifc_rst ##1 !st_q.preset_n;
    endsequence

    AST_RESET_PULSE: assert property ($rose(st_q.preset_n) |-> // R12
        $past(low_cnt_q) >= 12'(PPHP_RESET_CYC))
        else $error("peripheral reset pulse too short");
    AST_RESET_START: assert property (st_q.ifc_rst |-> // R12
        seq_ifc_rst ##1 !st_q.preset_n)
        else $error("peripheral reset not driven low");
    AST_RESET_STROBE: assert property (st_q.ifc_rst |=> !st_q.strobe) // R13
        else $error("strobe not cleared by interface reset");
    AST_RESET_DOUT: assert property (st_q.ifc_rst |=> // R14
        (dout_clear_fitted ? st_q.dout_pin == 16'h0000
                           : $stable(st_q.dout_pin)))
        else $error("data out wrong after interface reset");
    AST_RESET_KEEP: assert property (st_q.ifc_rst && !wr |=> // R15
        $stable(st_q.aux) && $stable(st_q.dir_pin))
        else $error("aux or direction changed by interface reset");
    AST_STROBE_CLEAR: assert property (st_q.strobe && to_busy // R3
        && !st_q.ifc_rst |=> !st_q.strobe)
        else $error("strobe not cleared on busy edge");
    AST_OUT_ORDER: assert property ($rose(st_q.strobe) && !st_q.inp // R2
        |-> !st_q.dir_pin && $past(st_q.fsm) == PPHP_S_DELAY)
        else $error("output strobe without direction low and delay");
    AST_IN_DIR: assert property ($rose(st_q.strobe) && st_q.inp // R5
        |-> st_q.dir_pin)
        else $error("input strobe without direction high");
    AST_BYTE_LANE: assert property ($rose(st_q.strobe) && !st_q.inp // R18
        && !st_q.word |-> (st_q.dout_pin ^ pol) >> 8 == 16'h0000)
        else $error("upper data lines not zero on byte output");
    AST_FULL_WAIT: assert property (st_q.fsm == PPHP_S_ARM && !pulse // R20
        && (busy_lvl || st_q.strobe) && !st_q.ifc_rst
        |=> st_q.fsm == PPHP_S_ARM)
        else $error("full mode started without ready");
endmodule

// file: pphp_periph.sv
`timescale 1ns/1ps
module pphp_periph (
    // clock
    input wire logic clk,
    // bench control: hold flag busy and ignore the strobe
    input wire logic stall,
    // inv: ready-pulse peripheral, both pin senses flipped, data held late
    input wire logic inv,
    // link as seen from the peripheral
    input wire logic strobe,
    input wire logic [15:0] dout,
    input wire logic dir_in,
    output logic flag,
    output logic [15:0] din
);
    int lag = 3;
    int n;
    logic [15:0] cap_q[$];
    logic [15:0] src_q[$];

    // busy-pulse peripheral, ready-pulse with inv; pin high on the flag means busy unless inv is set
    initial begin
        flag = 1'b0;
        din = 16'h5a5a;
        forever begin
            @(posedge clk);
            flag <= stall ^ inv;
            if ((strobe ^ inv) === 1'b1 && !stall) begin
                if (dir_in) begin
                    din <= src_q.pop_front();
                end else begin
                    cap_q.push_back(dout);
                end
                repeat (lag) @(posedge clk);
                flag <= ~inv;
                n = 0;
                while ((strobe ^ inv) === 1'b1 && n < 100) begin
                    @(posedge clk);
                    n++;
                end
                // hold time over without inv: do not leave the old value standing
                if (!inv) din <= ~din;
                repeat (lag) @(posedge clk);
                flag <= inv;
                // ready-edge capture needs data past the ready edge
                if (inv) begin
                    repeat (lag + 2) @(posedge clk);
                    din <= ~din;
                end
            end
        end
    end
endmodule

// file: parallel_pulse_handshake_port_tb.sv
`timescale 1ns/1ps
module parallel_pulse_handshake_port_tb;
    import pphp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mode, dlow, fit, stall, strobe, dir, aux0, aux1, prst_n, flag;
    logic inv, bec;
    logic [15:0] din, dout, w;
    int error_cnt = 0;
    int checks = 0;
    int n;
    int exp_q[$];

    pphp_port u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .handshake_mode_select(mode),
        .busy_edge_clocking(bec), .strobe_active_low(inv),
        .flag_active_low(inv), .data_active_low(dlow),
        .dout_clear_fitted(fit), .peripheral_flag(flag), .data_in(din),
        .peripheral_control_strobe(strobe), .direction_in(dir),
        .data_out(dout), .aux_output_zero(aux0), .aux_output_one(aux1),
        .periph_reset_n(prst_n));
    pphp_periph u_per (.clk(clk), .stall(stall), .inv(inv), .strobe(strobe),
        .dout(dout), .dir_in(dir), .flag(flag), .din(din));

    always #5 clk = ~clk;

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one apb transfer; waits for pready without assuming a latency
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 1, pready);
    endtask

    task wait_idle;
        int k;
        k = 0;
        apb(1'b0, PPHP_REG_STATUS, 0);
        while (rd[0] !== 1'b0 && k < 100) begin
            apb(1'b0, PPHP_REG_STATUS, 0);
            k++;
        end
        chk("active", 0, rd[0]);
    endtask

    // expected units on the wire for an output command
    task out_run(input int cmd, input logic [15:0] v);
        if (cmd[2]) begin
            exp_q.push_back(v);
        end else if (cmd[3]) begin
            exp_q.push_back(v[15:8]);
            exp_q.push_back(v[7:0]);
        end else begin
            exp_q.push_back(v[7:0]);
        end
        apb(1'b1, PPHP_REG_DOUT, v);
        apb(1'b1, PPHP_REG_CMD, cmd);
        wait_idle;
    endtask

    task out_cmp;
        logic [15:0] g;
        while (exp_q.size() > 0) begin
            g = 16'hxxxx;
            if (u_per.cap_q.size() > 0) g = u_per.cap_q.pop_front();
            chk("captured", exp_q.pop_front(), {16'h0, g});
        end
        chk("extra units", 0, u_per.cap_q.size());
    endtask

    task in_run(input int cmd);
        int a, b, e;
        a = $urandom_range(65535);
        b = $urandom_range(65535);
        u_per.src_q.push_back(a[15:0]);
        if (cmd[3]) u_per.src_q.push_back(b[15:0]);
        e = cmd[2] ? a : cmd[3] ? ((a & 255) << 8) | (b & 255) : a & 255;
        apb(1'b1, PPHP_REG_CMD, cmd);
        wait_idle;
        chk("direction", 1, dir);
        apb(1'b0, PPHP_REG_DIN, 0);
        chk("din", e, rd);
    endtask

    task prst_pulse;
        n = 0;
        while (prst_n !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (prst_n === 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("reset pulse", 1, n >= 1500 && n < 1600);
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mode = 1'b1;
        dlow = 1'b0;
        fit = 1'b0;
        stall = 1'b0;
        inv = 1'b0;
        bec = 1'b1;
        void'($urandom(36012));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // register table and unmapped place
        apb(1'b0, PPHP_REG_DELAY, 0);
        chk("delay reset", PPHP_DELAY_RST, rd);
        chk("aux reset", 2'b11, {aux1, aux0});
        chk("prst idle", 1, prst_n);
        apb(1'b0, 8'h1c, 0);
        chk("slverr", 1, err);
        $display("test registers done");
        // pulse byte output with a long strobe delay
        w = 16'($urandom());
        apb(1'b1, PPHP_REG_DELAY, 20);
        exp_q.push_back(w[7:0]);
        apb(1'b1, PPHP_REG_DOUT, w);
        apb(1'b1, PPHP_REG_CMD, 1);
        n = 0;
        while (strobe !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("strobe delay", 1, n >= 20 && n <= 24);
        chk("dir out", 0, dir);
        wait_idle;
        chk("strobe clear", 0, strobe);
        chk("byte lanes", w[7:0], dout);
        out_cmp;
        apb(1'b1, PPHP_REG_DELAY, 2);
        // pair then word, back to back in pulse mode
        out_run(9, 16'($urandom()));
        out_run(5, 16'($urandom()));
        out_cmp;
        $display("test pulse output done");
        in_run(3);
        in_run(11);
        in_run(7);
        $display("test pulse input done");
        // direct word access and data polarity
        w = 16'($urandom());
        apb(1'b1, PPHP_REG_DIRECT, w);
        repeat (2) @(posedge clk);
        chk("direct out", w, dout);
        dlow <= 1'b1;
        apb(1'b1, PPHP_REG_DIRECT, w);
        repeat (2) @(posedge clk);
        chk("direct low", 16'(~w), dout);
        dlow <= 1'b0;
        apb(1'b0, PPHP_REG_DIRECT, 0);
        chk("direct in", din, rd);
        repeat (2) @(posedge clk);
        chk("direct dir", 1, dir);
        $display("test direct done");
        // full mode waits while the flag shows busy
        mode <= 1'b0;
        stall <= 1'b1;
        repeat (5) @(posedge clk);
        w = 16'($urandom());
        exp_q.push_back(w[7:0]);
        apb(1'b1, PPHP_REG_DOUT, w);
        apb(1'b1, PPHP_REG_CMD, 1);
        repeat (30) @(posedge clk);
        chk("full hold", 0, strobe);
        stall <= 1'b0;
        wait_idle;
        out_cmp;
        $display("test full mode done");
        // interface reset with a strobe left standing
        mode <= 1'b1;
        apb(1'b1, PPHP_REG_AUX, 1);
        stall <= 1'b1;
        apb(1'b1, PPHP_REG_CMD, 1);
        n = 0;
        while (strobe !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("pulse no ready", 1, strobe);
        apb(1'b1, PPHP_REG_CMD, 32'h11);
        prst_pulse;
        chk("strobe reset", 0, strobe);
        chk("aux kept", 2'b10, {aux1, aux0});
        chk("dir kept", 0, dir);
        chk("dout kept", w[7:0], dout);
        stall <= 1'b0;
        fit <= 1'b1;
        apb(1'b1, PPHP_REG_CMD, 16);
        prst_pulse;
        chk("dout cleared", 0, dout);
        chk("no capture", 0, u_per.cap_q.size());
        $display("test interface reset done");
        // ready pulses served in full mode with flipped senses, ready edge
        stall <= 1'b1;
        inv <= 1'b1;
        bec <= 1'b0;
        mode <= 1'b0;
        repeat (8) @(posedge clk);
        stall <= 1'b0;
        repeat (8) @(posedge clk);
        chk("strobe idle", 1, strobe);
        in_run(3);
        chk("strobe done", 1, strobe);
        $display("test ready pulses done");
        give_verdict;
    end

    // watchdog: the tests need about 3500 cycles
    initial begin
        #200000;
        error_cnt++;
        give_verdict;
    end
endmodule
